// file: test/card_model.sv
`timescale 1ns/10ps
`default_nettype none
module card_model (
   // Card state chosen by the bench
   input  wire logic                        dat3_high,
   input  wire logic                        irq_low,
   // Host drive and resolved pin levels
   input  wire sdio_cfg_pkg::pin_drive_type pin_drive,
   output logic [3:0]                       dat_in,
   output logic                             cmd_in,
   output logic                             ready_busy_in
);
   // Pull-ups keep released lines high; host drives only in pin test mode
   wire logic host_dat = pin_drive.mode & ~pin_drive.dat_oe_n;
   wire logic host_cmd = pin_drive.mode & ~pin_drive.cmd_oe_n;
   assign dat_in        = host_dat ? pin_drive.dat : {dat3_high, 1'b1, ~irq_low, 1'b1};
   assign cmd_in        = host_cmd ? pin_drive.cmd : 1'b1;
   assign ready_busy_in = 1'b1;
endmodule : card_model
`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   typedef struct {bit pin; logic [31:0] e; logic [31:0] m;} note_type;
   logic        mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, timeout_start = 1'b0;
   logic        card_idle = 1'b1, read_wait_ack = 1'b0, cmd_od_or_to = 1'b0;
   logic        dat3_high = 1'b0, irq_low = 1'b0, rd_phase = 1'b0, pin_chk = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] data_timeout_value = 16'h0001;
   logic [15:0] c;
   sdio_cfg_pkg::response_type rsp = '0;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, cmd_in, ready_busy_in, cmd_timeout_arm, cmd_open_drain;
   wire logic cmd_long_timeout, read_wait_request, data_timeout, wake_request;
   wire logic [3:0] dat_in;
   wire logic [4:0] status;
   wire sdio_cfg_pkg::pin_drive_type pin_drive;
   wire logic [31:0] pins_seen = {6'h0, pin_drive, data_timeout, wake_request, cmd_timeout_arm,
      cmd_open_drain, cmd_long_timeout, read_wait_request, status};
   int        fail_count = 0, cmp_count = 0, cycles = 0;
   note_type  notes[$];
   note_type  n;
   sdio_config_card_detect_wake sdio_config_card_detect_wake_i (.hready(hreadyout), .*);
   card_model card_model_i (.*);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial forever #5 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   // Oldest note is settled against whatever result shows at this edge
   always @(posedge mclk) begin
      if ((rd_phase && hreadyout) || pin_chk) begin
         n = notes.pop_front();
         if (n.pin) cmp_pin(n.e, n.m);
         else cmp_bus(n.e, n.m);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_word(input string s, input logic [31:0] e, g, m);
      cmp_count++;
      if ((g & m) !== (e & m)) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", s, e & m, g & m);
      end
   endtask : cmp_word
   task automatic cmp_bus(input logic [31:0] e, m);
      cmp_word("hrdata", e, hrdata, m);
   endtask : cmp_bus
   task automatic cmp_pin(input logic [31:0] e, m);
      cmp_word("pins", e, pins_seen, m);
   endtask : cmp_pin
   task automatic idle(input int k);
      repeat (k) @(posedge mclk);
   endtask : idle
   // Master holds each phase until hready is seen high at an edge
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= sdio_cfg_pkg::HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rd_phase <= !w;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd_phase <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
      notes.push_back('{1'b0, e, m});
      bus(1'b0, a, 32'h0);
   endtask : rd
   // Strobe drops a full cycle before it may rise again
   task automatic chk(input logic [31:0] m, e);
      notes.push_back('{1'b1, e, m});
      pin_chk <= 1'b1;
      @(posedge mclk);
      pin_chk <= 1'b0;
      @(posedge mclk);
   endtask : chk
   task automatic resp(input logic [15:0] cf, input logic [3:0] k, input logic [7:0] s,
                       input logic [4:0] e);
      wr(sdio_cfg_pkg::CONFIG_ADDR, {16'h0, cf});
      rsp <= {1'b1, k, s};
      @(posedge mclk);
      rsp <= '0;
      idle(2);
      chk(32'h1F, {27'h0, e});
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
   endtask : resp
   task automatic pulse_start;
      timeout_start <= 1'b1;
      @(posedge mclk);
      timeout_start <= 1'b0;
   endtask : pulse_start
   task automatic give_verdict;
      if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      c = 16'($urandom(32'hF89D));
      idle(10);
      rst <= 1'b0;
      @(posedge mclk);
      rd(sdio_cfg_pkg::CONFIG_ADDR, 32'h0, 32'hFFFFFFFF);
      rd(sdio_cfg_pkg::PINTEST_ADDR, 32'h2740, 32'hFFFFFFFF);
      rd(8'h00, 32'h0, 32'hFFFFFFFF);
      read_wait_ack <= 1'b1;
      // Card-detect and interrupt events stay off here so only the plain decodes move
      for (int i = 0; i < 4; i++) begin
         c = (i < 2) ? 16'($urandom) & 16'hFFF2 : 16'h0050 | (i[0] ? 16'h0002 : 16'h0000);
         cmd_od_or_to <= 1'($urandom);
         wr(sdio_cfg_pkg::CONFIG_ADDR, {16'h0, c});
         rd(sdio_cfg_pkg::CONFIG_ADDR, {16'h0, c}, 32'hFFFFFFFF);
         chk(32'h1E0, {23'h0, c[15], ~c[6] & cmd_od_or_to, c[6] & cmd_od_or_to,
             c[1] & c[4], 5'h0});
      end
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h12);
      idle(3);
      chk(32'h30, 32'h30);
      read_wait_ack <= 1'b0;
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      chk(32'h1F, 32'h0);
      card_idle <= 1'b0;
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0204);
      dat3_high <= 1'b1;
      idle(5);
      chk(32'h1F, 32'h0);
      card_idle <= 1'b1;
      idle(5);
      chk(32'h21F, 32'h201);
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0004);
      chk(32'h200, 32'h0);
      dat3_high <= 1'b0;
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0804);
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      idle(5);
      chk(32'h21F, 32'h001);
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0404);
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      dat3_high <= 1'b1;
      idle(5);
      chk(32'h1F, 32'h1);
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      idle(5);
      chk(32'h1F, 32'h0);
      dat3_high <= 1'b0;
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0101);
      irq_low <= 1'b1;
      idle(5);
      chk(32'h21F, 32'h202);
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0001);
      chk(32'h200, 32'h0);
      irq_low <= 1'b0;
      idle(5);
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      // Each status bit alone, with its enable off then on
      for (int b = 2; b < 5; b++) begin
         for (int en = 0; en < 2; en++) begin
            resp(en ? 16'h1 << (10 + b) : 16'h0, 4'h8, 8'h1 << b, en ? 5'h4 : 5'h0);
         end
      end
      resp(16'h8000, 4'h2, 8'h01, 5'h04);
      resp(16'h0000, 4'h2, 8'h01, 5'h00);
      resp(16'h0080, 4'h5, 8'h00, 5'h00);
      resp(16'h0000, 4'h5, 8'h00, 5'h08);
      wr(sdio_cfg_pkg::PINTEST_ADDR, 32'h4000);
      chk(32'h1F, 32'h1F);
      rd(sdio_cfg_pkg::STATUS_ADDR, 32'h1F, 32'hFFFFFFFF);
      wr(sdio_cfg_pkg::STATUS_ADDR, 32'h1F);
      wr(sdio_cfg_pkg::PINTEST_ADDR, 32'h0500);
      rd(sdio_cfg_pkg::PINTEST_ADDR, 32'h2740, 32'hFFFFFFFF);
      wr(sdio_cfg_pkg::PINTEST_ADDR, 32'h9AF5);
      chk(32'h200, 32'h0);
      wr(sdio_cfg_pkg::MODE_ADDR, 32'h1);
      chk(32'h200, 32'h200);
      rd(sdio_cfg_pkg::PINTEST_ADDR, 32'hBAF5, 32'hFFFFFFFF);
      // Pin drive word sits above the eleven status and control bits
      chk(32'h03FFFA00, 32'h0353AA00);
      rd(sdio_cfg_pkg::MODE_ADDR, 32'h1, 32'hFFFFFFFF);
      wr(sdio_cfg_pkg::MODE_ADDR, 32'h0);
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0000);
      chk(32'h03FFFA00, 32'h01D7A800);
      // Unscaled: a value of one expires after two single cycles
      pulse_start();
      chk(32'h400, 32'h0);
      chk(32'h400, 32'h400);
      wr(sdio_cfg_pkg::CONFIG_ADDR, 32'h0020);
      pulse_start();
      idle(1000);
      chk(32'h400, 32'h0);
      idle(1100);
      chk(32'h400, 32'h400);
      give_verdict();
   end
endmodule : testbench
`default_nettype wire

// file: verilog/sdio_cfg_pkg.sv
`default_nettype none
package sdio_cfg_pkg;
   // Byte addresses of the register words
   localparam logic [7:0]  CONFIG_ADDR   = 8'h34;
   localparam logic [7:0]  PINTEST_ADDR  = 8'h38;
   localparam logic [7:0]  STATUS_ADDR   = 8'h3C;
   localparam logic [7:0]  MODE_ADDR     = 8'h40;
   // Configuration register bit positions
   localparam int R5E_BIT   = 15;
   localparam int S4E_BIT   = 14;
   localparam int S3E_BIT   = 13;
   localparam int S2E_BIT   = 12;
   localparam int POL_BIT   = 11;
   localparam int EDGE_BIT  = 10;
   localparam int CARD_DETECT_WAKE_ENABLE_BIT  = 9;
   localparam int IWE_BIT   = 8;
   localparam int R4C_BIT   = 7;
   localparam int XTO_BIT   = 6;
   localparam int PRE_BIT   = 5;
   localparam int RWREQ_BIT = 4;
   localparam int CDE_BIT   = 2;
   localparam int RWE_BIT   = 1;
   localparam int SDIO_IRQ_ENABLE_BIT  = 0;
   // Implemented bits of the configuration word; bit 3 is reserved
   localparam logic [15:0] CONFIG_MASK  = 16'hFFF7;
   localparam logic [15:0] CONFIG_RESET = 16'h0000;
   // Pin test register bit positions
   localparam int WAKE_OUTPUT_VALUE_BIT = 15;
   localparam int SSB_BIT  = 14;
   localparam int RDY_BIT  = 13;
   localparam int DATA_LINE_DIRECTION_BIT = 12;
   localparam int DAT_LSB  = 8;
   localparam int COMMAND_LINE_DIRECTION_BIT = 7;
   localparam int COMMAND_LINE_VALUE_BIT = 6;
   localparam int MCK_BIT  = 5;
   localparam int SCK_BIT  = 4;
   localparam logic [15:0] PINTEST_RESET = 16'h0000;
   // Status register bit positions
   localparam int ST_CD_BIT   = 0;
   localparam int ST_CARD_INTERRUPT_FLAG_BIT = 1;
   localparam int ST_CERR_BIT = 2;
   localparam int ST_COMMAND_CRC_ERROR_FLAG_BIT = 3;
   localparam int ST_CRW_BIT  = 4;
   localparam int STATUS_W    = 5;
   // Response status bits examined for R1/R1b
   localparam int RSP_B2 = 2;
   localparam int RSP_B3 = 3;
   localparam int RSP_B4 = 4;
   // Prescaler
   localparam int          PRESCALE_DIV = 1024;
   localparam logic [9:0]  PRESCALE_MAX = 10'h3FF;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

   // Response from the command engine
   typedef struct packed {
      logic        valid;
      logic        is_r1;
      logic        is_r4;
      logic        is_r5;
      logic        crc_bad;
      logic [7:0]  status;
   } response_type;

   // Pin test drive values
   typedef struct packed {
      logic       mode;
      logic       wake;
      logic       dat_oe_n;
      logic [3:0] dat;
      logic       cmd_oe_n;
      logic       cmd;
      logic       mck;
      logic       sck;
      logic [3:0] cs;
   } pin_drive_type;
endpackage : sdio_cfg_pkg
`default_nettype wire

// file: verilog/sdio_config_card_detect_wake.sv
`timescale 1ns/10ps
`default_nettype none
module sdio_config_card_detect_wake #(
   parameter int TIMEOUT_W = 16
) (
   // Clock and reset
   input  wire logic                      mclk,
   input  wire logic                      rst,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [7:0]                haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [31:0]               hwdata,
   input  wire logic                      hready,
   output logic [31:0]                    hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // Card pins (inputs, unsynchronised)
   input  wire logic [3:0]                dat_in,
   input  wire logic                      cmd_in,
   input  wire logic                      ready_busy_in,
   // Pin test drive
   output var sdio_cfg_pkg::pin_drive_type pin_drive,
   // Command and data engine side
   input  wire logic                      card_idle,
   input  wire sdio_cfg_pkg::response_type rsp,
   input  wire logic                      read_wait_ack,
   input  wire logic                      cmd_od_or_to,
   input  wire logic [TIMEOUT_W-1:0]      data_timeout_value,
   input  wire logic                      timeout_start,
   output logic                           cmd_timeout_arm,
   output logic                           cmd_open_drain,
   output logic                           cmd_long_timeout,
   output logic                           read_wait_request,
   output logic                           data_timeout,
   output logic [sdio_cfg_pkg::STATUS_W-1:0] status,
   // System wake request
   output logic                           wake_request
);

   logic [15:0]                     config_reg;
   logic [15:0]                     pintest;
   logic                            pin_test_mode;
   logic [sdio_cfg_pkg::STATUS_W-1:0] next_status;
   logic [3:0]                      dat_meta;
   logic [3:0]                      dat_sync;
   logic                            rdy_meta;
   logic                            rdy_sync;
   logic                            cmd_meta;
   logic                            cmd_sync;
   logic                            dat3_prev;
   logic                            ap_valid;
   logic                            ap_write;
   logic [7:0]                      ap_addr;
   logic [9:0]                      pre_cnt;
   logic [TIMEOUT_W-1:0]            to_cnt;
   logic                            to_run;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode; single-cycle answer, never waits
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   wire   bus_take  = hsel && hready && (htrans == sdio_cfg_pkg::HTRANS_NONSEQ);
   wire   wr_cfg    = ap_valid && ap_write && (ap_addr == sdio_cfg_pkg::CONFIG_ADDR);
   wire   wr_pin    = ap_valid && ap_write && (ap_addr == sdio_cfg_pkg::PINTEST_ADDR);
   wire   wr_stat   = ap_valid && ap_write && (ap_addr == sdio_cfg_pkg::STATUS_ADDR);
   wire   wr_mode   = ap_valid && ap_write && (ap_addr == sdio_cfg_pkg::MODE_ADDR);

   // Address phase capture
   always_ff @(posedge mclk) begin
      if (rst) begin
         ap_valid <= 1'b0;
         ap_write <= 1'b0;
         ap_addr  <= 8'h00;
      end else begin
         ap_valid <= bus_take;
         ap_write <= hwrite;
         ap_addr  <= haddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for pin inputs
   always_ff @(posedge mclk) begin
      if (rst) begin
         dat_meta <= 4'h0;
         dat_sync <= 4'h0;
         rdy_meta <= 1'b1;
         rdy_sync <= 1'b1;
         cmd_meta <= 1'b0;
         cmd_sync <= 1'b0;
      end else begin
         dat_meta <= dat_in;
         dat_sync <= dat_meta;
         rdy_meta <= ready_busy_in;
         rdy_sync <= rdy_meta;
         cmd_meta <= cmd_in;
         cmd_sync <= cmd_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration fields
   wire cfg_pol   = config_reg[sdio_cfg_pkg::POL_BIT];
   wire cfg_edge  = config_reg[sdio_cfg_pkg::EDGE_BIT];
   wire cfg_cde   = config_reg[sdio_cfg_pkg::CDE_BIT];
   wire cfg_sdio_irq_enable  = config_reg[sdio_cfg_pkg::SDIO_IRQ_ENABLE_BIT];

   // Card-detect condition after polarity, synchronised copy for the flag
   wire dat3_cond = dat_sync[3] ^ cfg_pol;
   wire dat3_last = dat3_prev ^ cfg_pol;
   wire cd_event  = cfg_cde && card_idle &&
                    (cfg_edge ? (dat3_cond && !dat3_last) : dat3_cond);
   // DAT1 held low signals an interrupt, whether or not the card is idle
   wire irq_event = cfg_sdio_irq_enable && !dat_sync[1];

   // Asynchronous wake path straight from the pins; edge mode still
   // reports the level, as no clock exists to see an edge while asleep
   wire cd_async  = cfg_cde && card_idle && (dat_in[3] ^ cfg_pol);
   wire irq_async = cfg_sdio_irq_enable && card_idle && !dat_in[1];
   wire wake_func = (cd_async && config_reg[sdio_cfg_pkg::CARD_DETECT_WAKE_ENABLE_BIT]) ||
                    (irq_async && config_reg[sdio_cfg_pkg::IWE_BIT]);
   assign wake_request = pin_test_mode ? pintest[sdio_cfg_pkg::WAKE_OUTPUT_VALUE_BIT]
                                       : wake_func;

   always_ff @(posedge mclk) begin
      if (rst) begin
         dat3_prev <= 1'b0;
      end else begin
         dat3_prev <= dat_sync[3];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Response error checks
   wire r1_err = rsp.valid && rsp.is_r1 &&
      ((config_reg[sdio_cfg_pkg::S4E_BIT] && rsp.status[sdio_cfg_pkg::RSP_B4]) ||
       (config_reg[sdio_cfg_pkg::S3E_BIT] && rsp.status[sdio_cfg_pkg::RSP_B3]) ||
       (config_reg[sdio_cfg_pkg::S2E_BIT] && rsp.status[sdio_cfg_pkg::RSP_B2]));
   wire r5_err = rsp.valid && rsp.is_r5 && config_reg[sdio_cfg_pkg::R5E_BIT] &&
                 (rsp.status != 8'h00);
   wire crc_err = rsp.valid && rsp.crc_bad &&
                  !(rsp.is_r4 && config_reg[sdio_cfg_pkg::R4C_BIT]);
   assign cmd_timeout_arm = config_reg[sdio_cfg_pkg::R5E_BIT];

   // Command bit meaning
   assign cmd_long_timeout = config_reg[sdio_cfg_pkg::XTO_BIT] && cmd_od_or_to;
   assign cmd_open_drain   = !config_reg[sdio_cfg_pkg::XTO_BIT] && cmd_od_or_to;

   // Read wait only when mode enabled
   assign read_wait_request = config_reg[sdio_cfg_pkg::RWE_BIT] &&
                              config_reg[sdio_cfg_pkg::RWREQ_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Status flags: set wins over write-one clear
   wire force_all = wr_pin && hwdata[sdio_cfg_pkg::SSB_BIT];
   wire [sdio_cfg_pkg::STATUS_W-1:0] set_vec =
      {read_wait_request && read_wait_ack, crc_err, r1_err || r5_err,
       irq_event, cd_event};
   wire [sdio_cfg_pkg::STATUS_W-1:0] clr_vec =
      wr_stat ? hwdata[sdio_cfg_pkg::STATUS_W-1:0] : {sdio_cfg_pkg::STATUS_W{1'b0}};
   assign next_status = force_all ? {sdio_cfg_pkg::STATUS_W{1'b1}}
                                  : ((status & ~clr_vec) | set_vec);

   always_ff @(posedge mclk) begin
      if (rst) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Configuration, pin test and mode registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         config_reg    <= sdio_cfg_pkg::CONFIG_RESET;
         pintest       <= sdio_cfg_pkg::PINTEST_RESET;
         pin_test_mode <= 1'b0;
      end else begin
         if (wr_cfg) begin
            config_reg <= hwdata[15:0] & sdio_cfg_pkg::CONFIG_MASK;
         end
         if (wr_pin) begin
            // Force bit is a pulse, never stored
            pintest <= {hwdata[15], 1'b0, hwdata[13:0]};
         end
         if (wr_mode) begin
            pin_test_mode <= hwdata[0];
         end
      end
   end

   // Pin drive from the pin test register; output enables only in test mode
   always_ff @(posedge mclk) begin
      if (rst) begin
         pin_drive <= '{mode: 1'b0, wake: 1'b0, dat_oe_n: 1'b1, dat: 4'h0,
                        cmd_oe_n: 1'b1, cmd: 1'b0, mck: 1'b0, sck: 1'b0, cs: 4'h0};
      end else begin
         pin_drive.mode     <= pin_test_mode;
         pin_drive.wake     <= pintest[sdio_cfg_pkg::WAKE_OUTPUT_VALUE_BIT];
         pin_drive.dat_oe_n <= !(pin_test_mode && pintest[sdio_cfg_pkg::DATA_LINE_DIRECTION_BIT]);
         pin_drive.dat      <= pintest[sdio_cfg_pkg::DAT_LSB +: 4];
         pin_drive.cmd_oe_n <= !(pin_test_mode && pintest[sdio_cfg_pkg::COMMAND_LINE_DIRECTION_BIT]);
         pin_drive.cmd      <= pintest[sdio_cfg_pkg::COMMAND_LINE_VALUE_BIT];
         pin_drive.mck      <= pintest[sdio_cfg_pkg::MCK_BIT];
         pin_drive.sck      <= pintest[sdio_cfg_pkg::SCK_BIT];
         pin_drive.cs       <= pintest[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin test readback: inputs show the pins, outputs the written values
   wire [3:0] dat_rd = pintest[sdio_cfg_pkg::DATA_LINE_DIRECTION_BIT] ? pintest[sdio_cfg_pkg::DAT_LSB +: 4]
                                                       : dat_sync;
   wire       cmd_rd = pintest[sdio_cfg_pkg::COMMAND_LINE_DIRECTION_BIT] ? pintest[sdio_cfg_pkg::COMMAND_LINE_VALUE_BIT]
                                                       : cmd_sync;
   wire [15:0] pin_rd = {pintest[sdio_cfg_pkg::WAKE_OUTPUT_VALUE_BIT], 1'b0, rdy_sync,
                         pintest[sdio_cfg_pkg::DATA_LINE_DIRECTION_BIT], dat_rd,
                         pintest[sdio_cfg_pkg::COMMAND_LINE_DIRECTION_BIT], cmd_rd,
                         pintest[5:0]};

   // Read mux registered for the data phase
   wire rd_take = bus_take && !hwrite;
   always_ff @(posedge mclk) begin
      if (rst) begin
         hrdata <= sdio_cfg_pkg::ZERO_WORD;
      end else if (rd_take) begin
         case (haddr)
            sdio_cfg_pkg::CONFIG_ADDR:  hrdata <= {16'h0000, config_reg};
            sdio_cfg_pkg::PINTEST_ADDR: hrdata <= {16'h0000, pin_rd};
            sdio_cfg_pkg::STATUS_ADDR:  hrdata <= {27'h0, status};
            sdio_cfg_pkg::MODE_ADDR:    hrdata <= {31'h0, pin_test_mode};
            default:                    hrdata <= sdio_cfg_pkg::ZERO_WORD;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Data timeout counter; prescaler makes each unit 1024 cycles
   wire unit_tick = !config_reg[sdio_cfg_pkg::PRE_BIT] ||
                    (pre_cnt == sdio_cfg_pkg::PRESCALE_MAX);
   always_ff @(posedge mclk) begin
      if (rst) begin
         pre_cnt      <= 10'h000;
         to_cnt       <= '0;
         to_run       <= 1'b0;
         data_timeout <= 1'b0;
      end else if (timeout_start) begin
         pre_cnt      <= 10'h000;
         to_cnt       <= data_timeout_value;
         to_run       <= 1'b1;
         data_timeout <= 1'b0;
      end else if (to_run) begin
         pre_cnt <= unit_tick ? 10'h000 : pre_cnt + 10'h001;
         if (unit_tick) begin
            if (to_cnt == '0) begin
               to_run       <= 1'b0;
               data_timeout <= 1'b1;
            end else begin
               to_cnt <= to_cnt - 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_crc_r4_mask: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r4 && config_reg[sdio_cfg_pkg::R4C_BIT] && !force_all
       && !status[sdio_cfg_pkg::ST_COMMAND_CRC_ERROR_FLAG_BIT])
      |=> !status[sdio_cfg_pkg::ST_COMMAND_CRC_ERROR_FLAG_BIT])
      else $error("R4 response set CRC flag while check disabled");
   a_wake_cd_gate: assert property (@(posedge mclk) disable iff (rst)
      (!pin_test_mode && !config_reg[sdio_cfg_pkg::CARD_DETECT_WAKE_ENABLE_BIT]
       && !config_reg[sdio_cfg_pkg::IWE_BIT]) |-> !wake_request)
      else $error("wake raised while both wake enables clear");
   a_wake_irq_on: assert property (@(posedge mclk) disable iff (rst)
      (!pin_test_mode && irq_async && config_reg[sdio_cfg_pkg::IWE_BIT]) |-> wake_request)
      else $error("interrupt wake missing");
   a_read_wait_gate: assert property (@(posedge mclk) disable iff (rst)
      !config_reg[sdio_cfg_pkg::RWE_BIT] |-> !read_wait_request)
      else $error("read wait issued while mode disabled");
   a_force_all: assert property (@(posedge mclk) disable iff (rst)
      force_all |=> (&status))
      else $error("force did not set all flags");
   a_cd_flag_set: assert property (@(posedge mclk) disable iff (rst)
      cd_event |=> status[sdio_cfg_pkg::ST_CD_BIT])
      else $error("card detect flag not set");
   a_reset_cfg: assert property (@(posedge mclk)
      $fell(rst) |-> (config_reg == 16'h0000))
      else $error("configuration not zero after reset");
   a_r1_err_b4: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r1 && rsp.status[4] && config_reg[sdio_cfg_pkg::S4E_BIT])
      |=> status[sdio_cfg_pkg::ST_CERR_BIT])
      else $error("bit 4 status error missed");
   a_prescale_unit: assert property (@(posedge mclk) disable iff (rst)
      (timeout_start && config_reg[sdio_cfg_pkg::PRE_BIT])
      |=> !data_timeout [*8])
      else $error("prescaled timeout expired too early");

   // Error and status flag, command routing, flag retention, pin release and timeout checks
   a_r1_mask_off: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r1 && !rsp.is_r5 && !force_all
       && !status[sdio_cfg_pkg::ST_CERR_BIT] && !config_reg[sdio_cfg_pkg::S4E_BIT]
       && !config_reg[sdio_cfg_pkg::S3E_BIT] && !config_reg[sdio_cfg_pkg::S2E_BIT])
      |=> !status[sdio_cfg_pkg::ST_CERR_BIT])
      else $error("masked status bit raised error");
   a_r1_err_b3: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r1 && rsp.status[sdio_cfg_pkg::RSP_B3]
       && config_reg[sdio_cfg_pkg::S3E_BIT]) |=> status[sdio_cfg_pkg::ST_CERR_BIT])
      else $error("bit 3 status error missed");
   a_r1_err_b2: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r1 && rsp.status[sdio_cfg_pkg::RSP_B2]
       && config_reg[sdio_cfg_pkg::S2E_BIT]) |=> status[sdio_cfg_pkg::ST_CERR_BIT])
      else $error("bit 2 status error missed");
   a_r5_err_set: assert property (@(posedge mclk) disable iff (rst)
      (rsp.valid && rsp.is_r5 && config_reg[sdio_cfg_pkg::R5E_BIT] && rsp.status != 8'h00)
      |=> status[sdio_cfg_pkg::ST_CERR_BIT])
      else $error("R5 status error missed");
   a_cmd_bit_split: assert property (@(posedge mclk) disable iff (rst)
      cmd_od_or_to |-> (cmd_long_timeout == config_reg[sdio_cfg_pkg::XTO_BIT])
                       && (cmd_open_drain != config_reg[sdio_cfg_pkg::XTO_BIT]))
      else $error("command bit routed to wrong meaning");
   a_cd_idle_gate: assert property (@(posedge mclk) disable iff (rst)
      (!card_idle && !force_all && !status[sdio_cfg_pkg::ST_CD_BIT])
      |=> !status[sdio_cfg_pkg::ST_CD_BIT])
      else $error("card detect flag set while card busy");
   a_irq_flag_set: assert property (@(posedge mclk) disable iff (rst)
      irq_event |=> status[sdio_cfg_pkg::ST_CARD_INTERRUPT_FLAG_BIT])
      else $error("card interrupt flag not set");
   a_rw_flag_set: assert property (@(posedge mclk) disable iff (rst)
      (read_wait_request && read_wait_ack) |=> status[sdio_cfg_pkg::ST_CRW_BIT])
      else $error("read wait active flag not set");
   a_flags_sticky: assert property (@(posedge mclk) disable iff (rst)
      !wr_stat |=> ((status & $past(status)) == $past(status)))
      else $error("status flag cleared without a write");
   a_pins_released: assert property (@(posedge mclk) disable iff (rst)
      !pin_test_mode |=> (pin_drive.dat_oe_n && pin_drive.cmd_oe_n))
      else $error("pin driven outside pin test mode");
   a_timeout_single: assert property (@(posedge mclk) disable iff (rst)
      (timeout_start && !config_reg[sdio_cfg_pkg::PRE_BIT] && data_timeout_value == 1)
      ##1 !timeout_start ##1 !timeout_start |=> data_timeout)
      else $error("unscaled timeout did not expire after two cycles");

endmodule : sdio_config_card_detect_wake
`default_nettype wire
